// file: common/rpp_params.svh
`ifndef RPP_PARAMS_SVH
`define RPP_PARAMS_SVH

// register byte offsets (no offsets printed; chosen locally)
`define RPP_KPB_OFFSET 12'h000
`define RPP_UPB_OFFSET 12'h004
`define RPP_RMSZ_OFFSET 12'h008
`define RPP_UDB_OFFSET 12'h00C
`define RPP_STAT_OFFSET 12'h010
`define RPP_ADDR_W 12

// base field position and fixed-zero span
`define RPP_BASE_MSB 15
`define RPP_BASE_LSB 10
`define RPP_BASE_MASK 32'h0000_FC00
`define RPP_RESET_VAL 32'h0000_0000
`define RPP_RMSZ_RESET 32'h0001_0000

// data ram offset width
`define RPP_OFS_W 17

`endif

// file: common/rpp_pkg.sv
package rpp_pkg;

    typedef enum logic [3:0] {
        RPP_KDATA = 4'b0001,
        RPP_KPROG = 4'b0010,
        RPP_UDATA = 4'b0100,
        RPP_UPROG = 4'b1000
    } rpp_region_e;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic valid;
    } rpp_addr_phase_s;

    typedef struct packed {
        logic [16:0] offset;
        logic valid;
    } rpp_access_s;

    typedef struct packed {
        rpp_region_e region;
        logic out_of_range;
    } rpp_class_s;

endpackage : rpp_pkg

// file: rtl/rpp_partition_regs.sv
// Operation
// - kernel program base holds writable bits 15-10, offset into data ram
// - user program base holds writable bits 15-10, offset into data ram
// - bits 9-0 of both bases read zero; bases step by 1 KB
// - bits 31-16 of both bases ignore writes, read zero
// - reset clears both bases; all ram becomes kernel data
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "rpp_params.svh"

module rpp_partition_regs
(
    // ahb-lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // access classifier
    input wire rpp_pkg::rpp_access_s ram_access,
    output rpp_pkg::rpp_class_s ram_class
);

    // ********************************************************
    // address phase capture
    // ********************************************************
    rpp_pkg::rpp_addr_phase_s aph_q;
    rpp_pkg::rpp_addr_phase_s aph_d;

    always_comb
    begin
        aph_d = aph_q;
        if (hready)
        begin
            aph_d.valid = hsel && htrans[1];
            aph_d.write = hwrite;
            aph_d.addr = haddr[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            aph_q <= '0;
        end
        else
        begin
            aph_q <= aph_d;
        end
    end

    // ********************************************************
    // registers
    // ********************************************************
    logic [5:0] kpb_q;
    logic [5:0] kpb_d;
    logic [5:0] upb_q;
    logic [5:0] upb_d;
    logic [31:0] rmsz_q;
    logic [31:0] rmsz_d;
    logic [5:0] udb_q;
    logic [5:0] udb_d;
    logic wr_en;

    assign wr_en = aph_q.valid && aph_q.write;

    always_comb
    begin
        kpb_d = kpb_q;
        upb_d = upb_q;
        rmsz_d = rmsz_q;
        udb_d = udb_q;
        if (wr_en)
        begin
            case (aph_q.addr)
                `RPP_KPB_OFFSET: kpb_d = hwdata[`RPP_BASE_MSB:`RPP_BASE_LSB];
                `RPP_UPB_OFFSET: upb_d = hwdata[`RPP_BASE_MSB:`RPP_BASE_LSB];
                // ram size kept 1 KB aligned like the bases
                `RPP_RMSZ_OFFSET: rmsz_d = hwdata & 32'h0001_FC00;
                `RPP_UDB_OFFSET: udb_d = hwdata[`RPP_BASE_MSB:`RPP_BASE_LSB];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            kpb_q <= 6'h0;
            upb_q <= 6'h0;
            rmsz_q <= `RPP_RMSZ_RESET;
            udb_q <= 6'h0;
        end
        else
        begin
            kpb_q <= kpb_d;
            upb_q <= upb_d;
            rmsz_q <= rmsz_d;
            udb_q <= udb_d;
        end
    end

    // ********************************************************
    // read data
    // ********************************************************
    logic [31:0] kpb_full;
    logic [31:0] upb_full;
    logic [31:0] udb_full;
    logic order_err;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // fixed zero bits around the field
    assign kpb_full = {16'h0000, kpb_q, 10'h000};
    assign upb_full = {16'h0000, upb_q, 10'h000};
    assign udb_full = {16'h0000, udb_q, 10'h000};

    // software ordering is not enforced, only reported
    assign order_err = (kpb_full > rmsz_q) || (upb_full > rmsz_q)
        || ((upb_q != 6'h0) && (upb_q <= udb_q));

    always_comb
    begin
        rdata_d = rdata_q;
        if (hready && hsel && htrans[1] && !hwrite)
        begin
            // next base and size values, so a base or size read right behind a write sees the new word
            case (haddr[11:0])
                `RPP_KPB_OFFSET: rdata_d = {16'h0000, kpb_d, 10'h000};
                `RPP_UPB_OFFSET: rdata_d = {16'h0000, upb_d, 10'h000};
                `RPP_RMSZ_OFFSET: rdata_d = rmsz_d;
                `RPP_UDB_OFFSET: rdata_d = {16'h0000, udb_d, 10'h000};
                `RPP_STAT_OFFSET: rdata_d = {31'h0000_0000, order_err};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ********************************************************
    // access classifier
    // ********************************************************
    rpp_pkg::rpp_class_s class_d;
    rpp_pkg::rpp_class_s class_q;
    logic [16:0] kp_ofs;
    logic [16:0] ud_ofs;
    logic [16:0] up_ofs;

    assign kp_ofs = {1'b0, kpb_q, 10'h000};
    assign ud_ofs = {1'b0, udb_q, 10'h000};
    assign up_ofs = {1'b0, upb_q, 10'h000};

    // zero base means the region is absent, so low ram stays kernel data
    // region compare
    always_comb
    begin
        class_d = class_q;
        if (ram_access.valid)
        begin
            class_d.out_of_range = ({15'h0000, ram_access.offset} >= rmsz_q);
            if ((upb_q != 6'h0) && (ram_access.offset >= up_ofs))
            begin
                class_d.region = rpp_pkg::RPP_UPROG;
            end
            else if ((udb_q != 6'h0) && (ram_access.offset >= ud_ofs))
            begin
                class_d.region = rpp_pkg::RPP_UDATA;
            end
            else if ((kpb_q != 6'h0) && (ram_access.offset >= kp_ofs))
            begin
                class_d.region = rpp_pkg::RPP_KPROG;
            end
            else
            begin
                class_d.region = rpp_pkg::RPP_KDATA;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            class_q <= '{region: rpp_pkg::RPP_KDATA, out_of_range: 1'b0};
        end
        else
        begin
            class_q <= class_d;
        end
    end

    assign ram_class = class_q;

endmodule : rpp_partition_regs

// file: test/rpp_cpu_model.sv
`timescale 1ns/10ps
module rpp_cpu_model
(
    // clock
    input wire logic hclk,
    // request from bench
    input wire logic go,
    input wire logic [16:0] ofs,
    // access toward classifier
    output rpp_pkg::rpp_access_s acc
);
    // idle offset flips so a stale value never looks held
    always_ff @(posedge hclk)
        acc <= go ? {ofs, 1'b1} : {~acc.offset, 1'b0};
endmodule : rpp_cpu_model

// file: test/rpp_partition_regs_assertions.sv
`timescale 1ns/10ps
module rpp_chk
(
    // bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    // classifier side
    input wire rpp_pkg::rpp_access_s ram_access,
    input wire rpp_pkg::rpp_class_s ram_class
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_b;
    logic [6:0] kb;
    assign rd_b = hsel && htrans[1] && !hwrite && haddr[11:3] == 9'h000;
    assign kb = ram_access.offset[16:10];
    low_zero_a: assert property (rd_b |=> hrdata[9:0] == 10'h000)
        else $error("base low bits set");
    high_zero_a: assert property (rd_b |=> hrdata[31:16] == 16'h0000)
        else $error("base high bits set");
    reset_kdata_a: assert property ($rose(hresetn) |-> ram_class == 5'h02)
        else $error("class after reset");
    region_onehot_a: assert property ($onehot(ram_class.region))
        else $error("region not one-hot");
    first_kb_a: assert property (ram_access.valid && kb == 7'h00 |=> ram_class.region
        == rpp_pkg::RPP_KDATA) else $error("first kb not kernel data");
    top_range_a: assert property (ram_access.valid && kb == 7'h7f |=>
        ram_class.out_of_range) else $error("top offset in range");
    class_hold_a: assert property (!ram_access.valid |=> $stable(ram_class))
        else $error("class moved while idle");
    cover property (rd_b);
    cover property (hsel && htrans[1] && hwrite);
    cover property (ram_class.region == rpp_pkg::RPP_UPROG);
endmodule : rpp_chk
bind rpp_partition_regs rpp_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
    .ram_access(ram_access), .ram_class(ram_class));

// file: test/tb_rpp_partition_regs.sv
`timescale 1ns/10ps
module tb_rpp_partition_regs;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic [16:0] ofs = 0;
    rpp_pkg::rpp_access_s acc;
    rpp_pkg::rpp_class_s cls;
    int n_fail = 0, checks = 0, m[4];
    rpp_partition_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ram_access(acc), .ram_class(cls));
    rpp_cpu_model cpu_u (.hclk(hclk), .go(go), .ofs(ofs), .acc(acc));
    initial forever #5 hclk = ~hclk;
    task tally_and_finish;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task step;
        int i;
        for (i = 0; i < 9; i++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                break;
        end
        if (i == 9)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask : step
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        step();
        htrans <= 2'b00;
        hwdata <= d;
        step();
        r = hrdata;
        if (w)
            m[a[3:2]] = d & (a[3:2] == 2 ? 32'h0001_fc00 : 32'h0000_fc00);
    endtask : xfer
    function automatic logic [31:0] ord();
        return {31'h0000_0000, (m[0] > m[2]) || (m[1] > m[2]) || (m[1] != 0 && m[1] <= m[3])};
    endfunction : ord
    task rd(input logic [11:0] a);
        xfer(0, a, 32'h0000_0000);
        chk(r, a < 12'h010 ? m[a[3:2]] : a == 12'h010 ? ord() : 32'h0000_0000);
        chk({31'h0000_0000, hreadyout}, 32'h0000_0001);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask : rd
    function automatic logic [4:0] cl(int o);
        logic [3:0] g;
        g = (m[1] != 0 && o >= m[1]) ? 4'b1000 : (m[3] != 0 && o >= m[3]) ? 4'b0100 :
            (m[0] != 0 && o >= m[0]) ? 4'b0010 : 4'b0001;
        return {g, o >= m[2]};
    endfunction : cl
    initial
    begin
        void'($urandom(32'hfc42d389));
        m = '{0, 0, 32'h0001_0000, 0};
        repeat (16) @(posedge hclk);
        hresetn <= 1;
        for (int a = 0; a < 16; a += 4) rd(12'(a));
        repeat (12)
        begin
            xfer(1, 0, $urandom());
            xfer(1, 4, $urandom());
            rd(0);
            rd(4);
        end
        rd(12'h020);
        // ordered layout kept within the ram size
        xfer(1, 0, 32'h0000_1000);
        xfer(1, 12'h00c, 32'h0000_4000);
        xfer(1, 4, 32'h0000_8000);
        xfer(1, 8, 32'h0000_c000);
        for (int a = 0; a < 20; a += 4) rd(12'(a));
        for (int i = 0; i < 70; i++)
        begin
            @(posedge hclk);
            ofs <= i < 8 ? 17'(m[i % 4] - i / 4) : i == 8 ? 17'h1_ffff : i == 9 ?
                17'h0_03ff : 17'($urandom());
            go <= 1;
            @(posedge hclk);
            go <= 0;
            @(posedge hclk);
            #1 chk({27'h000_0000, cls}, {27'h000_0000, cl(ofs)});
        end
        // user program base below user data base must be flagged
        xfer(1, 4, 32'h0000_2000);
        rd(12'h010);
        @(posedge hclk);
        hresetn <= 0;
        @(posedge hclk);
        hresetn <= 1;
        m = '{0, 0, 32'h0001_0000, 0};
        for (int a = 0; a < 16; a += 4) rd(12'(a));
        tally_and_finish();
    end
    initial
    begin
        #900000;
        n_fail++;
        tally_and_finish();
    end
endmodule : tb_rpp_partition_regs
